//--- hw/bfp_top.sv
/*
 * Buck converter fault supervisor: comparator qualification, gate command
 * gating, overcurrent window, hiccup timing, power-good and AHB-Lite regs.
 * Assumes comparator inputs are asynchronous; drivers add their own dead time.
 */
`timescale 1ns/100ps
module bfp_top (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// ahb-lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// analog comparators
	input  wire logic        uv_cmp_i,
	input  wire logic        ov_cmp_i,
	input  wire logic        ls_oc_cmp_i,
	input  wire logic        hs_oc_cmp_i,
	input  wire logic        hot_cmp_i,
	input  wire logic        lim_clamp_i,
	input  wire logic        pwm_cmp_i,
	input  wire logic        ss_done_i,
	// gate drive, soft-start and threshold select
	output logic             hs_drv_o,
	output logic             ls_drv_o,
	output logic             ss_en_o,
	output logic             lim_fixed_o,
	// open-drain power good
	output logic             pg_o,
	output logic             pg_oe_o
);
	bfp_cmp_if uv_c ();
	bfp_cmp_if ov_c ();
	bfp_cmp_if ls_c ();
	bfp_cmp_if hs_c ();
	bfp_cmp_if hot_c ();
	bfp_cmp_if lim_c ();
	bfp_cmp_if pwm_c ();
	bfp_cmp_if ssd_c ();

	bfp_pkg::bfp_state_type state_r;
	bfp_pkg::bfp_state_type state_nxt;
	logic        ctrl_en_r;
	logic [9:0]  per_cnt_r;
	logic        cyc_start;
	logic        switching;
	logic        on_nxt;
	logic [4:0]  blank_r;
	logic        sampled_r;
	logic        ls_sample;
	logic        ls_trip_r;
	logic        ev_cyc_r;
	logic [7:0]  win_r;
	logic [3:0]  oc_cnt;
	logic        oc_hic;
	logic [23:0] ss_cnt_r;
	logic [23:0] ss_len_r;
	logic [25:0] hic_cnt_r;
	logic        pg_oe_nxt;
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;

	function automatic logic [3:0] bfp_popcount(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction : bfp_popcount

	// comparator synchronisers and qualifiers
	assign uv_c.raw   = uv_cmp_i;
	assign uv_c.en    = (state_r == bfp_pkg::ST_RUN);
	assign ov_c.raw   = ov_cmp_i;
	assign ov_c.en    = (state_r == bfp_pkg::ST_RUN);
	assign ls_c.raw   = ls_oc_cmp_i;
	assign ls_c.en    = 1'h1;
	assign hs_c.raw   = hs_oc_cmp_i;
	assign hs_c.en    = 1'h1;
	assign hot_c.raw  = hot_cmp_i;
	assign hot_c.en   = 1'h1;
	assign lim_c.raw  = lim_clamp_i;
	assign lim_c.en   = 1'h1;
	assign pwm_c.raw  = pwm_cmp_i;
	assign pwm_c.en   = 1'h1;
	assign ssd_c.raw  = ss_done_i;
	assign ssd_c.en   = 1'h1;

	bfp_qual #(.LIMIT(bfp_pkg::UV_QUAL_CYC)) u_uv (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(uv_c));
	bfp_qual #(.LIMIT(bfp_pkg::OV_QUAL_CYC)) u_ov (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(ov_c));
	bfp_qual #(.LIMIT(0)) u_ls   (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(ls_c));
	bfp_qual #(.LIMIT(0)) u_hs   (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(hs_c));
	bfp_qual #(.LIMIT(0)) u_hot  (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(hot_c));
	bfp_qual #(.LIMIT(0)) u_lim  (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(lim_c));
	bfp_qual #(.LIMIT(0)) u_pwm  (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(pwm_c));
	bfp_qual #(.LIMIT(0)) u_ssd  (.mclk_i(mclk_i), .resetn_i(resetn_i), .cmp(ssd_c));

	// supervisor state machine
	assign oc_cnt = bfp_popcount(win_r);
	assign oc_hic = (oc_cnt >= 4'(bfp_pkg::OC_EVENTS));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bfp_pkg::ST_OFF: begin
				if (!hot_c.lvl) state_nxt = bfp_pkg::ST_SS;
			end
			bfp_pkg::ST_SS: begin
				// thermal and voltage faults stay masked here
				if (oc_hic) state_nxt = bfp_pkg::ST_HICCUP;
				else if (ssd_c.lvl) state_nxt = bfp_pkg::ST_RUN;
			end
			bfp_pkg::ST_RUN: begin
				if (hot_c.lvl) state_nxt = bfp_pkg::ST_TSD;
				else if (oc_hic) state_nxt = bfp_pkg::ST_HICCUP;
				else if (ov_c.qual) state_nxt = bfp_pkg::ST_OVP;
				else if (uv_c.qual) state_nxt = bfp_pkg::ST_HICCUP;
			end
			bfp_pkg::ST_OVP: begin
				if (hot_c.lvl) state_nxt = bfp_pkg::ST_TSD;
				else if (uv_c.lvl) state_nxt = bfp_pkg::ST_HICCUP;
			end
			bfp_pkg::ST_HICCUP: begin
				if (hot_c.lvl) state_nxt = bfp_pkg::ST_TSD;
				else if (hic_cnt_r == 26'h0000000) state_nxt = bfp_pkg::ST_SS;
			end
			bfp_pkg::ST_TSD: begin
				if (!hot_c.lvl) state_nxt = bfp_pkg::ST_SS;
			end
			default: begin
				state_nxt = bfp_pkg::ST_OFF;
			end
		endcase
		if (!ctrl_en_r) state_nxt = bfp_pkg::ST_OFF;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) state_r <= bfp_pkg::ST_OFF;
		else state_r <= state_nxt;
	end

	// soft-start length is measured so hiccup scales with the soft-start cap
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ss_cnt_r <= 24'h000000;
			ss_len_r <= 24'(bfp_pkg::SS_LEN_DEF);
		end else if (state_r != bfp_pkg::ST_SS) begin
			ss_cnt_r <= 24'h000000;
		end else if (state_nxt == bfp_pkg::ST_RUN) begin
			ss_len_r <= ss_cnt_r;
		end else if (ss_cnt_r != 24'hffffff) begin
			ss_cnt_r <= ss_cnt_r + 24'h000001;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) hic_cnt_r <= 26'h0000000;
		else if (state_nxt == bfp_pkg::ST_HICCUP && state_r != bfp_pkg::ST_HICCUP)
			hic_cnt_r <= {ss_len_r, 2'h0};
		else if (hic_cnt_r != 26'h0000000) hic_cnt_r <= hic_cnt_r - 26'h0000001;
	end

	// switching cycle and gate commands
	assign switching = (state_r == bfp_pkg::ST_SS) || (state_r == bfp_pkg::ST_RUN);
	assign cyc_start = (per_cnt_r == 10'h000);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) per_cnt_r <= 10'h000;
		else if (per_cnt_r == 10'(bfp_pkg::SW_PERIOD_CYC - 1)) per_cnt_r <= 10'h000;
		else per_cnt_r <= per_cnt_r + 10'h001;
	end

	always_comb begin
		on_nxt = hs_drv_o;
		if (!switching) on_nxt = 1'h0;
		else if (cyc_start) on_nxt = !ls_trip_r && pwm_c.lvl;
		else if (hs_c.lvl) on_nxt = 1'h0;
		else if (!pwm_c.lvl || per_cnt_r >= 10'(bfp_pkg::ON_MAX_CYC)) on_nxt = 1'h0;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hs_drv_o <= 1'h0;
			ls_drv_o <= 1'h0;
			ss_en_o  <= 1'h0;
		end else begin
			hs_drv_o <= on_nxt;
			ls_drv_o <= (switching && !on_nxt) || (state_nxt == bfp_pkg::ST_OVP);
			ss_en_o  <= (state_nxt == bfp_pkg::ST_SS) || (state_nxt == bfp_pkg::ST_RUN);
		end
	end

	// off-time blanking and single low-side sample per cycle
	// never at cycle start: a trip taken there would miss the high-side gate
	assign ls_sample = switching && ls_drv_o && !hs_drv_o && (blank_r == 5'h00)
		&& !sampled_r && !cyc_start;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) blank_r <= 5'h00;
		else if (hs_drv_o && !on_nxt) blank_r <= 5'(bfp_pkg::BLANK_CYC);
		else if (blank_r != 5'h00) blank_r <= blank_r - 5'h01;
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) sampled_r <= 1'h0;
		else if (cyc_start) sampled_r <= 1'h0;
		else if (ls_sample) sampled_r <= 1'h1;
	end

	// release is watched continuously, only the trip is sampled
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) ls_trip_r <= 1'h0;
		else if (!switching || !ls_c.lvl) ls_trip_r <= 1'h0;
		else if (ls_sample) ls_trip_r <= 1'h1;
	end

	// one event per cycle, window shifted at each cycle start
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ev_cyc_r <= 1'h0;
			win_r    <= 8'h00;
		end else if (!switching) begin
			ev_cyc_r <= 1'h0;
			win_r    <= 8'h00;
		end else if (cyc_start) begin
			ev_cyc_r <= 1'h0;
			win_r    <= {win_r[6:0], ev_cyc_r};
		end else if ((ls_sample && ls_c.lvl) || (hs_drv_o && hs_c.lvl)) begin
			ev_cyc_r <= 1'h1;
		end
	end

	// power good and threshold select
	assign pg_oe_nxt = !((state_r == bfp_pkg::ST_RUN) && !uv_c.lvl && !ov_c.lvl
		&& !ls_trip_r && !ev_cyc_r && !hot_c.lvl);

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pg_o         <= 1'h0;
			pg_oe_o      <= 1'h1;
			lim_fixed_o  <= 1'h0;
		end else begin
			pg_o         <= 1'h0;
			pg_oe_o      <= pg_oe_nxt;
			lim_fixed_o  <= lim_c.lvl;
		end
	end

	// ahb-lite slave, zero wait states, always okay
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_pend_r   <= 1'h0;
			wr_addr_r   <= 8'h00;
			hrdata_o    <= 32'h00000000;
			hreadyout_o <= 1'h1;
			hresp_o     <= 1'h0;
		end else begin
			wr_pend_r <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
			if (hsel_i && hready_i && htrans_i[1]) wr_addr_r <= haddr_i[7:0];
			hrdata_o <= 32'h00000000;
			if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
				case (haddr_i[7:0])
					bfp_pkg::REG_CTRL: begin
						hrdata_o[bfp_pkg::CTRL_EN_BIT] <= ctrl_en_r;
					end
					bfp_pkg::REG_STATUS: begin
						hrdata_o[bfp_pkg::ST_STATE_LSB +: 3] <= state_r;
						hrdata_o[bfp_pkg::ST_UV_BIT]         <= uv_c.lvl;
						hrdata_o[bfp_pkg::ST_OV_BIT]         <= ov_c.lvl;
						hrdata_o[bfp_pkg::ST_HOT_BIT]        <= hot_c.lvl;
						hrdata_o[bfp_pkg::ST_LSTRIP_BIT]     <= ls_trip_r;
						hrdata_o[bfp_pkg::ST_FIXED_BIT]      <= lim_fixed_o;
						hrdata_o[bfp_pkg::ST_OCCNT_LSB +: 4] <= oc_cnt;
						hrdata_o[bfp_pkg::ST_PGOOD_BIT]      <= !pg_oe_o;
					end
					default: begin
						hrdata_o <= 32'h00000000;
					end
				endcase
			end
			hreadyout_o <= 1'h1;
			hresp_o     <= 1'h0;
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) ctrl_en_r <= bfp_pkg::CTRL_EN_RST;
		else if (wr_pend_r && wr_addr_r == bfp_pkg::REG_CTRL) ctrl_en_r <= hwdata_i[bfp_pkg::CTRL_EN_BIT];
	end

	// checks
	sequence s_ovp_entered;
		state_r == bfp_pkg::ST_OVP;
	endsequence

	sequence s_fb_low;
		uv_c.lvl;
	endsequence

	a_hiccup_drives_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		state_r == bfp_pkg::ST_HICCUP && $past(state_r) == bfp_pkg::ST_HICCUP |-> !hs_drv_o && !ls_drv_o && pg_oe_o)
		else $error("drive or power good active in hiccup");
	a_tsd_drives_off: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		state_r == bfp_pkg::ST_TSD |=> !hs_drv_o && !ls_drv_o && pg_oe_o)
		else $error("drive or power good active in thermal shutdown");
	a_tsd_restart: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		state_r == bfp_pkg::ST_TSD && !hot_c.lvl && ctrl_en_r |=> state_r == bfp_pkg::ST_SS)
		else $error("no soft-start after cooling");
	a_ls_inhibit_hs: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		ls_trip_r |=> !hs_drv_o)
		else $error("high side on during low-side trip");
	a_hs_oc_cut: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		hs_drv_o && hs_c.lvl && !cyc_start |=> !hs_drv_o)
		else $error("on-time not ended on high-side trip");
	a_blank_no_sample: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		$fell(hs_drv_o) |-> !ls_sample [*8])
		else $error("low-side sampled inside blanking");
	a_window_hiccup: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		state_r == bfp_pkg::ST_RUN && oc_cnt >= 4'h3 && ctrl_en_r && !hot_c.lvl |=> state_r == bfp_pkg::ST_HICCUP)
		else $error("no hiccup after three overcurrent events");
	a_ss_uv_masked: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		state_r == bfp_pkg::ST_SS && $past(state_r) == bfp_pkg::ST_SS |-> !uv_c.qual && !ov_c.qual)
		else $error("voltage fault qualified in soft-start");
	a_pg_release: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!pg_oe_o |-> $past(state_r) == bfp_pkg::ST_RUN && !$past(uv_c.lvl) && !$past(ov_c.lvl))
		else $error("power good released outside window");
	a_ovp_ls_on: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		s_ovp_entered ##1 (state_r == bfp_pkg::ST_OVP) |-> ls_drv_o && !hs_drv_o && pg_oe_o)
		else $error("overvoltage drive state wrong");
	a_ovp_to_hiccup: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		s_ovp_entered and s_fb_low and !hot_c.lvl and ctrl_en_r |=> state_r == bfp_pkg::ST_HICCUP)
		else $error("overvoltage did not end in hiccup");

endmodule : bfp_top

//--- hw/bfp_pkg.sv
/*
 * Constants for the buck fault supervisor: register map, field positions,
 * reset values and timing counts.
 * Assumes a 125 MHz system clock; all times are converted to cycles here.
 */
package bfp_pkg;

	function automatic int bfp_ceil_div(input int num, input int den);
		return (num + den - 1) / den;
	endfunction : bfp_ceil_div

	localparam int CLK_PERIOD_NS = 8;

	// qualification, blanking and minimum off times
	localparam int UV_QUAL_NS   = 20000;
	localparam int UV_QUAL_CYC  = bfp_ceil_div(UV_QUAL_NS, CLK_PERIOD_NS);
	localparam int OV_QUAL_NS   = 5000;
	localparam int OV_QUAL_CYC  = bfp_ceil_div(OV_QUAL_NS, CLK_PERIOD_NS);
	localparam int BLANK_NS     = 150;
	localparam int BLANK_CYC    = bfp_ceil_div(BLANK_NS, CLK_PERIOD_NS);
	localparam int MIN_OFF_NS   = 330;
	localparam int MIN_OFF_CYC  = bfp_ceil_div(MIN_OFF_NS, CLK_PERIOD_NS);

	// switching period
	localparam int SW_FREQ_KHZ   = 300;
	localparam int SW_PERIOD_CYC = 1000000 / (SW_FREQ_KHZ * CLK_PERIOD_NS);
	localparam int ON_MAX_CYC    = SW_PERIOD_CYC - MIN_OFF_CYC;

	// overcurrent window and hiccup
	localparam int OC_EVENTS     = 3;
	localparam int OC_WINDOW     = 8;
	localparam int HICCUP_SHIFT  = 2;
	localparam int SS_LEN_DEF    = 125000;

	// register map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam int CTRL_EN_BIT        = 0;
	localparam logic CTRL_EN_RST      = 1'h0;
	localparam int ST_STATE_LSB       = 0;
	localparam int ST_UV_BIT          = 3;
	localparam int ST_OV_BIT          = 4;
	localparam int ST_HOT_BIT         = 5;
	localparam int ST_LSTRIP_BIT      = 6;
	localparam int ST_FIXED_BIT       = 7;
	localparam int ST_OCCNT_LSB       = 8;
	localparam int ST_PGOOD_BIT       = 12;

	typedef enum logic [2:0] {
		ST_OFF    = 3'b000,
		ST_SS     = 3'b001,
		ST_RUN    = 3'b010,
		ST_OVP    = 3'b011,
		ST_HICCUP = 3'b100,
		ST_TSD    = 3'b101
	} bfp_state_type;

endpackage : bfp_pkg

//--- hw/bfp_cmp_if.sv
/*
 * Carrier for one comparator between the supervisor and its qualifier.
 * Assumes raw is asynchronous to the clock.
 */
`timescale 1ns/100ps
interface bfp_cmp_if;
	logic raw;
	logic en;
	logic lvl;
	logic qual;
	modport qual_mp (input raw, input en, output lvl, output qual);
	modport user_mp (output raw, output en, input lvl, input qual);
endinterface : bfp_cmp_if

//--- hw/bfp_qual.sv
/*
 * Comparator synchroniser with optional persistence qualifier.
 * Assumes one clock; LIMIT of zero gives a plain synchronised level.
 */
`timescale 1ns/100ps
module bfp_qual #(
	parameter int LIMIT = 0
) (
	// clock and reset
	input  wire logic   mclk_i,
	input  wire logic   resetn_i,
	// comparator
	bfp_cmp_if.qual_mp  cmp
);
	logic        meta_r;
	logic        sync_r;
	logic [15:0] cnt_r;
	logic        qual_r;

	// first stage feeds only the second
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
		end else begin
			meta_r <= cmp.raw;
			sync_r <= meta_r;
		end
	end

	// any dropout restarts the timer
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r  <= 16'h0000;
			qual_r <= 1'h0;
		end else if (!cmp.en || !sync_r) begin
			cnt_r  <= 16'h0000;
			qual_r <= 1'h0;
		end else if (cnt_r == 16'(LIMIT)) begin
			qual_r <= 1'h1;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	assign cmp.lvl  = sync_r;
	assign cmp.qual = qual_r;

endmodule : bfp_qual

//--- tb/bfp_plant.sv
/*
 * Far-side model for the fault supervisor: pwm and current-sense comparators
 * and the soft-start ramp. Assumes the bench sets ramp and on-time lengths.
 */
`timescale 1ns/100ps
module bfp_plant (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	// gate and soft-start commands
	input  wire logic        hs_drv_i,
	input  wire logic        ss_en_i,
	// scenario controls
	input  wire logic        ls_req_i,
	input  wire logic        hs_req_i,
	input  wire logic [15:0] ss_len_i,
	input  wire logic [15:0] on_len_i,
	// comparator outputs
	output logic             pwm_cmp_o,
	output logic             ss_done_o,
	output logic             ls_oc_cmp_o,
	output logic             hs_oc_cmp_o
);
	logic [15:0] ss_cnt_r;
	logic [15:0] on_cnt_r;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ss_cnt_r    <= 16'h0;
			on_cnt_r    <= 16'h0;
			pwm_cmp_o   <= 1'b0;
			ss_done_o   <= 1'b0;
			ls_oc_cmp_o <= 1'b0;
			hs_oc_cmp_o <= 1'b0;
		end else begin
			// saturate so a long run never wraps back to not-done
			ss_cnt_r    <= !ss_en_i ? 16'h0 : (ss_cnt_r == 16'hffff) ? ss_cnt_r : ss_cnt_r + 16'h1;
			on_cnt_r    <= hs_drv_i ? on_cnt_r + 16'h1 : 16'h0;
			ss_done_o   <= ss_en_i && (ss_cnt_r >= ss_len_i);
			pwm_cmp_o   <= !(hs_drv_i && (on_cnt_r >= on_len_i));
			ls_oc_cmp_o <= ls_req_i;
			// high-side current only flows while the high side conducts
			hs_oc_cmp_o <= hs_req_i & hs_drv_i;
		end
	end
endmodule : bfp_plant

//--- tb/tb_top.sv
/*
 * Self-checking bench for the buck fault supervisor, register access over ahb-lite.
 * Assumes the design answers with zero or more wait states and an okay response.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	localparam logic [31:0] A_CT = {24'h0, bfp_pkg::REG_CTRL};
	localparam logic [31:0] A_ST = {24'h0, bfp_pkg::REG_STATUS};
	logic        mclk_i;
	logic        resetn_i;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic        hreadyout;
	logic        hresp;
	logic        uv, ov, hot, clamp, ls_req, hs_req;
	logic        ls_oc, hs_oc, pwm, ss_done;
	logic        hs_drv, ls_drv, ss_en, lim_fixed, pg, pg_oe;
	logic [15:0] ss_len;
	logic [15:0] on_len;
	int          fails = 0;
	int          tests_run = 0;
	int          cyc = 0;
	// open-drain line with its pull-up
	wire         pg_line = pg_oe ? pg : 1'b1;

	bfp_top uut (.mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
		.hreadyout_o(hreadyout), .hresp_o(hresp), .uv_cmp_i(uv), .ov_cmp_i(ov), .ls_oc_cmp_i(ls_oc),
		.hs_oc_cmp_i(hs_oc), .hot_cmp_i(hot), .lim_clamp_i(clamp), .pwm_cmp_i(pwm), .ss_done_i(ss_done),
		.hs_drv_o(hs_drv), .ls_drv_o(ls_drv), .ss_en_o(ss_en), .lim_fixed_o(lim_fixed), .pg_o(pg),
		.pg_oe_o(pg_oe));
	bfp_plant plant (.mclk_i(mclk_i), .resetn_i(resetn_i), .hs_drv_i(hs_drv), .ss_en_i(ss_en),
		.ls_req_i(ls_req), .hs_req_i(hs_req), .ss_len_i(ss_len), .on_len_i(on_len), .pwm_cmp_o(pwm),
		.ss_done_o(ss_done), .ls_oc_cmp_o(ls_oc), .hs_oc_cmp_o(hs_oc));

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	task automatic results();
		$display("counts: tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	// hang guard, well above the roughly 30k cycles the tests need
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 90000) begin
			fails++;
			results();
		end
	end

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge mclk_i);
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge mclk_i); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk_i); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : ahb

	task automatic wait_st(input logic [2:0] s, input int n);
		ahb(1'b0, A_ST, 32'h0, rd);
		for (int i = 0; i < n && rd[2:0] !== s; i++) begin
			ahb(1'b0, A_ST, 32'h0, rd);
		end
		`CHK(rd[2:0], s)
	endtask : wait_st

	task automatic wait_hs(input logic v, input int n);
		for (int i = 0; i < n && hs_drv !== v; i++) begin
			@(posedge mclk_i);
		end
		`CHK(hs_drv, v)
	endtask : wait_hs

	task automatic hs_quiet(input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge mclk_i);
			k += int'(hs_drv);
		end
		`CHK(k, 0)
	endtask : hs_quiet

	initial begin
		resetn_i = 1'b0;
		{haddr, htrans, hwrite, hwdata} = '0;
		{uv, ov, hot, clamp, ls_req, hs_req} = 6'h0;
		ss_len = 16'd3000;
		on_len = 16'd100;
		repeat (6) @(posedge mclk_i);
		resetn_i <= 1'b1;
		`CHK(pg_line, 1'b0)
		`CHK({hs_drv, ls_drv, hreadyout, hresp}, 4'h2)
		ahb(1'b0, A_CT, 32'h0, rd);
		`CHK(rd, 32'h0)
		ahb(1'b0, 32'h40, 32'h0, rd);
		`CHK(rd, 32'h0)
		wait_st(bfp_pkg::ST_OFF, 0);
		$display("test reset done");
		ahb(1'b1, A_CT, 32'h1, rd);
		wait_st(bfp_pkg::ST_SS, 8);
		uv <= 1'b1;
		hot <= 1'b1;
		repeat (2700) @(posedge mclk_i);
		wait_st(bfp_pkg::ST_SS, 0);
		`CHK(pg_line, 1'b0)
		uv <= 1'b0;
		hot <= 1'b0;
		wait_st(bfp_pkg::ST_RUN, 400);
		repeat (4) @(posedge mclk_i);
		`CHK(pg_line, 1'b1)
		ahb(1'b0, A_ST, 32'h0, rd);
		`CHK(rd[12], 1'b1)
		$display("test soft-start done");
		uv <= 1'b1;
		repeat (1000) @(posedge mclk_i);
		uv <= 1'b0;
		wait_st(bfp_pkg::ST_RUN, 0);
		uv <= 1'b1;
		repeat (2400) @(posedge mclk_i);
		wait_st(bfp_pkg::ST_RUN, 0);
		repeat (150) @(posedge mclk_i);
		wait_st(bfp_pkg::ST_HICCUP, 0);
		uv <= 1'b0;
		ss_len <= 16'd200;
		`CHK({hs_drv, ls_drv, ss_en, pg_line}, 4'h0)
		repeat (11800) @(posedge mclk_i);
		wait_st(bfp_pkg::ST_HICCUP, 0);
		wait_st(bfp_pkg::ST_SS, 300);
		`CHK(pg_line, 1'b0)
		wait_st(bfp_pkg::ST_RUN, 200);
		$display("test undervoltage done");
		wait_hs(1'b1, 900);
		// trip level stands across the high-side fall and is gone before blanking ends
		ls_req <= 1'b1;
		wait_hs(1'b0, 200);
		repeat (4) @(posedge mclk_i);
		ls_req <= 1'b0;
		wait_hs(1'b1, 450);
		ahb(1'b0, A_ST, 32'h0, rd);
		`CHK({rd[11:8], rd[6]}, 5'h00)
		wait_hs(1'b0, 200);
		ls_req <= 1'b1;
		hs_quiet(500);
		ahb(1'b0, A_ST, 32'h0, rd);
		`CHK(rd[6], 1'b1)
		ls_req <= 1'b0;
		wait_hs(1'b1, 430);
		wait_st(bfp_pkg::ST_RUN, 0);
		$display("test low-side trip done");
		repeat (4000) @(posedge mclk_i);
		for (int i = 0; i < 3; i++) begin
			wait_hs(1'b1, 450);
			ahb(1'b0, A_ST, 32'h0, rd);
			`CHK({rd[11:8], rd[2:0]}, {4'(i), bfp_pkg::ST_RUN})
			hs_req <= 1'b1;
			repeat (6) @(posedge mclk_i);
			`CHK(hs_drv, 1'b0)
			hs_req <= 1'b0;
		end
		wait_st(bfp_pkg::ST_HICCUP, 150);
		wait_st(bfp_pkg::ST_RUN, 600);
		$display("test overcurrent window done");
		hot <= 1'b1;
		wait_st(bfp_pkg::ST_TSD, 10);
		`CHK({hs_drv, ls_drv, ss_en, pg_line}, 4'h0)
		repeat (2000) @(posedge mclk_i);
		wait_st(bfp_pkg::ST_TSD, 0);
		hot <= 1'b0;
		wait_st(bfp_pkg::ST_SS, 10);
		`CHK(ss_en, 1'b1)
		wait_st(bfp_pkg::ST_RUN, 200);
		$display("test thermal done");
		ov <= 1'b1;
		repeat (700) @(posedge mclk_i);
		wait_st(bfp_pkg::ST_OVP, 0);
		`CHK({hs_drv, ls_drv, pg_line}, 3'h2)
		ov <= 1'b0;
		uv <= 1'b1;
		wait_st(bfp_pkg::ST_HICCUP, 10);
		uv <= 1'b0;
		$display("test overvoltage done");
		clamp <= 1'b1;
		repeat (4) @(posedge mclk_i);
		`CHK(lim_fixed, 1'b1)
		clamp <= 1'b0;
		repeat (4) @(posedge mclk_i);
		`CHK(lim_fixed, 1'b0)
		ahb(1'b1, A_CT, 32'h0, rd);
		wait_st(bfp_pkg::ST_OFF, 10);
		$display("test clamp and disable done");
		results();
	end
endmodule : tb_top
